// [mii_consts.svh]
// timing, field and reset constants of the multiply/divide issue interlock
`ifndef MII_CONSTS_SVH
`define MII_CONSTS_SVH
`define MII_CLK_PERIOD_NS 8
`define MII_GPR_MDU_DELAY 3'h4
`define MII_GPR_DSP_DELAY 3'h1
`define MII_GPR_NONE 3'h0
`define MII_ACC_MAC_WAIT 2'h1
`define MII_ACC_SHIFT_WAIT 2'h3
`define MII_ACC_NONE 2'h0
`define MII_DIV_LAT_8 6'h07
`define MII_DIV_LAT_16 6'h0f
`define MII_DIV_LAT_24 6'h17
`define MII_DIV_LAT_32 6'h1f
`define MII_DIV_SIGNED_EXTRA 6'h02
`define MII_OUFLAG_DEPTH 3'h5
`define MII_POS_LIMIT 6'h20
`define MII_CTL_POS_LSB 0
`define MII_CTL_POS_MSB 5
`define MII_CTL_CARRY_BIT 13
`define MII_CTL_COND_LSB 24
`define MII_CTL_COND_MSB 27
`define MII_POS_RESET 6'h00
`define MII_COND_RESET 4'h0
`define MII_BASE_PAIR 2'h0
`define MII_GPR_ZERO 5'h00
`define MII_ASC_CARRY_BIT 0
`define MII_CMP_COND_LSB 0
`define MII_CMP_COND_MSB 3
`endif

// [mii_issue_interlock.sv]
// issue and stall control of the multiply/divide unit
//
// Functional notes
// - new multiply may enter every cycle
// - divide one bit per clock, early-in skip
// - base pair access waits for pending divide write
// - register multiply ignores pending divide
// - multiply then accumulate or read: no stall
// - register result of multiply/read: 4 cycles
// - unsigned divide read: 7/15/23/31 cycles
// - signed divide read: 9/17/25/33 cycles
// - half write: accumulate waits 1, read 0
// - back-to-back accumulates repeat every cycle
// - register multiplies wait for write port
// - four accumulator pairs, all in this unit
// - position branch uses control position field
// - indexed loads check index and base
// - dsp alu register result: 1 cycle
// - saturating accumulate delays next by 1
// - shift/extract/insert wait 3 after write
// - delays per pair, shrink each cycle
// - repeat 1, or 2 after saturating
// - control fields staged in execute, memory
// - control read waits for late flag writers
// - carry, compare, control write: zero delay
`timescale 1ns/10ps
`include "mii_consts.svh"

module mii_issue_interlock (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // instruction from the integer issue stage
    input wire logic in_valid,
    input wire mii_pkg::mii_instr_t in_instr,
    // register file write port taken by integer instructions
    input wire logic wr_port_busy,
    // answer to the issue stage
    output mii_pkg::mii_out_t out
);

    mii_pkg::mii_state_t st_r;
    mii_pkg::mii_state_t st_nxt;

    function automatic logic [2:0] max3(input logic [2:0] a,
                                        input logic [2:0] b);
        max3 = (a > b) ? a : b;
    endfunction

    function automatic logic [1:0] max2(input logic [1:0] a,
                                        input logic [1:0] b);
        max2 = (a > b) ? a : b;
    endfunction

    // early-in: count bytes of the magnitude that carry information
    function automatic logic [5:0] div_stall(input logic [31:0] dividend,
                                             input logic is_signed);
        logic [31:0] mag;
        logic [5:0] lat;
        mag = (is_signed && dividend[31]) ? (32'h0 - dividend) : dividend;
        if (mag[31:8] == 24'h0) begin
            lat = `MII_DIV_LAT_8;
        end else if (mag[31:16] == 16'h0) begin
            lat = `MII_DIV_LAT_16;
        end else if (mag[31:24] == 8'h0) begin
            lat = `MII_DIV_LAT_24;
        end else begin
            lat = `MII_DIV_LAT_32;
        end
        // sign adjust costs the signed form two more cycles
        div_stall = is_signed ? lat + `MII_DIV_SIGNED_EXTRA : lat;
    endfunction

    function automatic logic gpr_busy(input mii_pkg::mii_state_t s,
                                      input logic [4:0] r);
        gpr_busy = (r != `MII_GPR_ZERO) && (s.gpr_cnt[r] != `MII_GPR_NONE);
    endfunction

    // true while the held instruction must not issue
    function automatic logic hazard(input mii_pkg::mii_state_t s);
        mii_pkg::mii_instr_t h;
        logic hz;
        logic div_pair;
        h = s.head;
        hz = 1'b0;
        // divider results land in the base pair only
        div_pair = (s.div_cnt != 6'h0) && (h.acc == `MII_BASE_PAIR);
        // both sources checked, covers indexed loads
        if (gpr_busy(s, h.src_a) || gpr_busy(s, h.src_b)) begin
            hz = 1'b1;
        end
        case (h.op)
            mii_pkg::OP_PRODUCT_TO_REGISTER: begin
                // no pair access, divide may still be running
                if (s.port_busy) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_ACCUMULATE,
            mii_pkg::OP_ACCUMULATE_SAT: begin
                if (s.mac_cnt[h.acc] != `MII_ACC_NONE || div_pair) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_READ_HALF: begin
                if (s.rd_cnt[h.acc] != `MII_ACC_NONE || div_pair) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_ACCUMULATOR_SHIFT,
            mii_pkg::OP_ACCUMULATOR_EXTRACT,
            mii_pkg::OP_ACCUMULATOR_SHIFT_INSERT: begin
                if (s.sh_cnt[h.acc] != `MII_ACC_NONE || div_pair) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_PRODUCT_TO_PAIR,
            mii_pkg::OP_WRITE_HALF: begin
                if (div_pair) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_SIGNED_QUOTIENT,
            mii_pkg::OP_UNSIGNED_QUOTIENT: begin
                // one divider: a second divide waits for the first
                if (s.div_cnt != 6'h0) begin
                    hz = 1'b1;
                end
            end
            mii_pkg::OP_CONTROL_REGISTER_READ: begin
                if (s.ouflag_cnt != 3'h0) begin
                    hz = 1'b1;
                end
            end
            default: begin
            end
        endcase
        hazard = hz;
    endfunction

    // multiply unit operations that may set overflow flags late
    function automatic logic late_flag(input mii_pkg::mii_op_t op);
        case (op)
            mii_pkg::OP_PRODUCT_TO_REGISTER,
            mii_pkg::OP_PRODUCT_TO_PAIR,
            mii_pkg::OP_ACCUMULATE,
            mii_pkg::OP_ACCUMULATE_SAT,
            mii_pkg::OP_ACCUMULATOR_SHIFT,
            mii_pkg::OP_ACCUMULATOR_EXTRACT,
            mii_pkg::OP_ACCUMULATOR_SHIFT_INSERT: late_flag = 1'b1;
            default: late_flag = 1'b0;
        endcase
    endfunction

    always_comb begin
        mii_pkg::mii_instr_t h;
        logic go;
        logic [2:0] gset;
        logic [1:0] mset;
        logic wr_acc;
        st_nxt = st_r;
        h = st_r.head;
        go = st_r.head_v && !hazard(st_r);
        gset = `MII_GPR_NONE;
        mset = `MII_ACC_NONE;
        wr_acc = 1'b0;

        // every countdown shrinks each cycle, intervening ones count
        for (int i = 0; i < 32; i++) begin
            if (st_r.gpr_cnt[i] != `MII_GPR_NONE) begin
                st_nxt.gpr_cnt[i] = st_r.gpr_cnt[i] - 3'h1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (st_r.mac_cnt[i] != `MII_ACC_NONE) begin
                st_nxt.mac_cnt[i] = st_r.mac_cnt[i] - 2'h1;
            end
            if (st_r.rd_cnt[i] != `MII_ACC_NONE) begin
                st_nxt.rd_cnt[i] = st_r.rd_cnt[i] - 2'h1;
            end
            if (st_r.sh_cnt[i] != `MII_ACC_NONE) begin
                st_nxt.sh_cnt[i] = st_r.sh_cnt[i] - 2'h1;
            end
        end
        // reaches zero once the divider is sure to win the pair
        if (st_r.div_cnt != 6'h0) begin
            st_nxt.div_cnt = st_r.div_cnt - 6'h1;
        end
        // late flag writers still in the multiply pipe
        if (st_r.ouflag_cnt != 3'h0) begin
            st_nxt.ouflag_cnt = st_r.ouflag_cnt - 3'h1;
        end
        st_nxt.ctl_ms = st_r.ctl_ex;
        // port contention seen a cycle late: costs one issue slot
        st_nxt.port_busy = wr_port_busy;

        if (go) begin
            case (h.op)
                mii_pkg::OP_PRODUCT_TO_REGISTER,
                mii_pkg::OP_READ_HALF: begin
                    gset = `MII_GPR_MDU_DELAY;
                end
                mii_pkg::OP_ACCUMULATOR_EXTRACT: begin
                    gset = `MII_GPR_MDU_DELAY;
                    wr_acc = 1'b1;
                end
                mii_pkg::OP_PRODUCT_TO_PAIR,
                mii_pkg::OP_ACCUMULATE: begin
                    // third stage result fed back, no accumulate wait
                    wr_acc = 1'b1;
                end
                mii_pkg::OP_ACCUMULATE_SAT: begin
                    mset = `MII_ACC_MAC_WAIT;
                    wr_acc = 1'b1;
                end
                mii_pkg::OP_WRITE_HALF,
                mii_pkg::OP_ACCUMULATOR_SHIFT,
                mii_pkg::OP_ACCUMULATOR_SHIFT_INSERT: begin
                    mset = `MII_ACC_MAC_WAIT;
                    wr_acc = 1'b1;
                end
                mii_pkg::OP_SIGNED_QUOTIENT: begin
                    st_nxt.div_cnt = div_stall(h.operand, 1'b1);
                end
                mii_pkg::OP_UNSIGNED_QUOTIENT: begin
                    st_nxt.div_cnt = div_stall(h.operand, 1'b0);
                end
                mii_pkg::OP_ALU_DSP,
                mii_pkg::OP_ADD_WITH_CARRY,
                mii_pkg::OP_CONDITIONAL_SELECT,
                mii_pkg::OP_VARIABLE_INSERT: begin
                    gset = `MII_GPR_DSP_DELAY;
                end
                mii_pkg::OP_ADD_SETTING_CARRY: begin
                    gset = `MII_GPR_DSP_DELAY;
                    st_nxt.ctl_ex.carry =
                        h.operand[`MII_ASC_CARRY_BIT];
                end
                mii_pkg::OP_VECTOR_COMPARE: begin
                    st_nxt.ctl_ex.cond =
                        h.operand[`MII_CMP_COND_MSB:`MII_CMP_COND_LSB];
                end
                mii_pkg::OP_CONTROL_REGISTER_WRITE: begin
                    st_nxt.ctl_ex.pos =
                        h.operand[`MII_CTL_POS_MSB:`MII_CTL_POS_LSB];
                    st_nxt.ctl_ex.carry = h.operand[`MII_CTL_CARRY_BIT];
                    st_nxt.ctl_ex.cond =
                        h.operand[`MII_CTL_COND_MSB:`MII_CTL_COND_LSB];
                end
                default: begin
                end
            endcase
            // register zero never carries a result
            if (gset != `MII_GPR_NONE && h.dest != `MII_GPR_ZERO) begin
                st_nxt.gpr_cnt[h.dest] =
                    max3(st_nxt.gpr_cnt[h.dest], gset);
            end
            // per pair: other pairs untouched
            if (wr_acc) begin
                st_nxt.mac_cnt[h.acc] =
                    max2(st_nxt.mac_cnt[h.acc], mset);
                st_nxt.sh_cnt[h.acc] = `MII_ACC_SHIFT_WAIT;
            end
            // conservative: every multiply, accumulate and accumulator shift op may touch the flags
            if (late_flag(h.op)) begin
                st_nxt.ouflag_cnt = `MII_OUFLAG_DEPTH;
            end
        end

        // head refills when empty or leaving this cycle
        if (!st_r.head_v || go) begin
            st_nxt.head_v = in_valid;
            st_nxt.head = in_instr;
        end

        st_nxt.out.go = go;
        st_nxt.out.op = go ? h.op : mii_pkg::OP_NONE;
        // branch decided on newest position, as an ordinary branch
        st_nxt.out.branch_taken = go &&
            (h.op == mii_pkg::OP_POSITION_TEST_BRANCH) &&
            (st_r.ctl_ex.pos >= `MII_POS_LIMIT);
        // shows the newest fields, as the next instruction sees them
        st_nxt.out.ctl = st_nxt.ctl_ex;
        // ready looks ahead so the issue stage never overruns the head
        st_nxt.out.ready = !(st_nxt.head_v && hazard(st_nxt));
    end

    // sync reset clears the struct, then sets the idle levels
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.ctl_ex.pos <= `MII_POS_RESET;
            st_r.ctl_ex.cond <= `MII_COND_RESET;
            st_r.ctl_ms.pos <= `MII_POS_RESET;
            st_r.out.ready <= 1'b1;
            st_r.out.op <= mii_pkg::OP_NONE;
            st_r.head.op <= mii_pkg::OP_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out = st_r.out;

endmodule // mii_issue_interlock

// [mii_issue_interlock_sva.sv]
// port assertions of the multiply/divide issue interlock
`timescale 1ns/10ps
`include "mii_consts.svh"
module mii_issue_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // issue stage side
    input wire logic in_valid,
    input wire mii_pkg::mii_instr_t in_instr,
    input wire logic wr_port_busy,
    input wire mii_pkg::mii_out_t out
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    logic go_u, go_s, go_q, go_b, go_m, go_p;
    assign go_u = out.go && out.op == mii_pkg::OP_UNSIGNED_QUOTIENT;
    assign go_s = out.go && out.op == mii_pkg::OP_SIGNED_QUOTIENT;
    assign go_q = go_u || go_s;
    assign go_b = out.go && out.op == mii_pkg::OP_POSITION_TEST_BRANCH;
    assign go_m = out.go && out.op == mii_pkg::OP_ACCUMULATE_SAT;
    assign go_p = out.go && out.op == mii_pkg::OP_PRODUCT_TO_REGISTER;
    reset_out_a: assert property (
        $rose(rstn) |-> out.ready && !out.go && out.ctl == '0)
        else $error("outputs not at reset level");
    op_idle_a: assert property (
        !out.go |-> out.op == mii_pkg::OP_NONE)
        else $error("op shown without issue");
    branch_src_a: assert property (
        out.branch_taken |-> go_b)
        else $error("branch taken without branch issue");
    branch_pos_a: assert property (
        go_b |-> out.branch_taken == (out.ctl.pos >= `MII_POS_LIMIT))
        else $error("branch outcome not from position field");
    udiv_gap_a: assert property (
        go_u |=> !go_q [*7])
        else $error("quotient issued during unsigned divide");
    sdiv_gap_a: assert property (
        go_s |=> !go_q [*8])
        else $error("quotient issued during signed divide");
    flag_wait_a: assert property (
        go_m |=> (out.op != mii_pkg::OP_CONTROL_REGISTER_READ) [*5])
        else $error("control read while flags may change");
    port_busy_a: assert property (
        $past(wr_port_busy, 2) && $past(wr_port_busy) |-> !go_p)
        else $error("register product issued on busy port");
endmodule // mii_issue_sva

bind mii_issue_interlock mii_issue_sva u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .in_valid(in_valid),
    .in_instr(in_instr), .wr_port_busy(wr_port_busy), .out(out));

// [mii_issue_src.sv]
// behavioural integer issue stage feeding the interlock
`timescale 1ns/10ps
module mii_issue_src (
    // clock
    input wire logic ref_clk,
    // answer from the interlock
    input wire logic ready,
    // offer to the interlock
    output logic in_valid,
    output mii_pkg::mii_instr_t in_instr,
    // an offer never taken
    output logic stuck
);
    initial begin
        in_valid = 1'b0;
        in_instr = '0;
        stuck = 1'b0;
    end
    // entered just after an edge, returns just after the taking edge
    task automatic offer(input mii_pkg::mii_instr_t i);
        logic rdy;
        int n;
        in_valid = 1'b1;
        in_instr = i;
        for (n = 0; n < 64; n++) begin
            rdy = ready;
            @(posedge ref_clk);
            #1;
            if (rdy) break;
        end
        if (n == 64) stuck = 1'b1;
    endtask
    // released lines flip so a stale offer cannot pass
    task automatic idle();
        in_valid = 1'b0;
        in_instr = ~in_instr;
    endtask
endmodule // mii_issue_src

// [mii_issue_tb.sv]
// self-checking bench of the multiply/divide issue interlock
`timescale 1ns/10ps
`include "mii_consts.svh"
module testbench;
    logic ref_clk, rstn, wr_port_busy, in_valid, stuck;
    mii_pkg::mii_instr_t in_instr;
    mii_pkg::mii_out_t out;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int gq[$];
    logic [31:0] oq[$];
    logic bq[$];
    mii_issue_interlock u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .in_valid(in_valid), .in_instr(in_instr),
        .wr_port_busy(wr_port_busy), .out(out));
    mii_issue_src u_src (.ref_clk(ref_clk), .ready(out.ready),
        .in_valid(in_valid), .in_instr(in_instr), .stuck(stuck));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // issue log, one entry per go pulse
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (out.go === 1'b1) begin
            gq.push_back(cyc);
            oq.push_back(out.op);
            bq.push_back(out.branch_taken);
        end
    end
    task automatic end_sim();
        $display("mismatches %0d of %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %0h not %0h", $time, seen, exp);
        end
    endtask
    // longest countdown is under 40 cycles
    task automatic drain();
        repeat (40) @(posedge ref_clk);
        #1;
        gq.delete();
        oq.delete();
        bq.delete();
    endtask
    task automatic wait_go(input int n);
        int k;
        for (k = 0; k < 80 && gq.size() < n; k++) begin
            @(posedge ref_clk);
            #1;
        end
        if (gq.size() < n || stuck) begin
            err_count++;
            $display("CHECK FAILED at %0t: issue missing", $time);
            end_sim();
        end
    endtask
    // a writes r or its pair, b reads them; gap between go pulses
    task automatic pair(input mii_pkg::mii_op_t oa, input logic [1:0] aa,
        input mii_pkg::mii_op_t ob, input logic [1:0] ab,
        input logic [4:0] r, input logic [31:0] v, input int gap);
        drain();
        u_src.offer('{oa, aa, r, 5'h00, 5'h00, v});
        u_src.offer('{ob, ab, 5'h00, r, r, 32'h0});
        u_src.idle();
        wait_go(2);
        check(gq[1] - gq[0], gap);
        check(oq[1], ob);
    endtask
    task automatic t_mac();
        pair(mii_pkg::OP_PRODUCT_TO_PAIR, 2'h1, mii_pkg::OP_ACCUMULATE,
            2'h1, 5'h00, 32'h0, 1);
        pair(mii_pkg::OP_ACCUMULATE, 2'h1, mii_pkg::OP_READ_HALF,
            2'h1, 5'h00, 32'h0, 1);
        pair(mii_pkg::OP_ACCUMULATE_SAT, 2'h1, mii_pkg::OP_ACCUMULATE,
            2'h1, 5'h00, 32'h0, 1 + `MII_ACC_MAC_WAIT);
        pair(mii_pkg::OP_WRITE_HALF, 2'h2, mii_pkg::OP_ACCUMULATE,
            2'h2, 5'h00, 32'h0, 1 + `MII_ACC_MAC_WAIT);
        pair(mii_pkg::OP_WRITE_HALF, 2'h2, mii_pkg::OP_READ_HALF,
            2'h2, 5'h00, 32'h0, 1);
    endtask
    task automatic t_gpr();
        pair(mii_pkg::OP_PRODUCT_TO_REGISTER, 2'h0, mii_pkg::OP_ALU,
            2'h0, 5'h03, 32'h0, 1 + `MII_GPR_MDU_DELAY);
        pair(mii_pkg::OP_READ_HALF, 2'h3, mii_pkg::OP_INDEXED_LOAD,
            2'h0, 5'h04, 32'h0, 1 + `MII_GPR_MDU_DELAY);
        pair(mii_pkg::OP_ALU_DSP, 2'h0, mii_pkg::OP_ALU,
            2'h0, 5'h05, 32'h0, 1 + `MII_GPR_DSP_DELAY);
        pair(mii_pkg::OP_PRODUCT_TO_REGISTER, 2'h0,
            mii_pkg::OP_PRODUCT_TO_REGISTER, 2'h0, 5'h00, 32'h0, 1);
    endtask
    task automatic t_div();
        logic [31:0] uv[4] = '{32'h7f, 32'hffff, 32'hffffff, 32'h80000000};
        logic [31:0] sv[4] = '{32'hffffff81, 32'h7fff, 32'hff800001,
            32'h7fffffff};
        int lat[4] = '{`MII_DIV_LAT_8, `MII_DIV_LAT_16, `MII_DIV_LAT_24,
            `MII_DIV_LAT_32};
        for (int i = 0; i < 4; i++) begin
            pair(mii_pkg::OP_UNSIGNED_QUOTIENT, 2'h0, mii_pkg::OP_READ_HALF,
                2'h0, 5'h00, uv[i], 1 + lat[i]);
            pair(mii_pkg::OP_SIGNED_QUOTIENT, 2'h0,
                mii_pkg::OP_READ_HALF, 2'h0, 5'h00, sv[i],
                1 + lat[i] + `MII_DIV_SIGNED_EXTRA);
        end
        pair(mii_pkg::OP_SIGNED_QUOTIENT, 2'h0,
            mii_pkg::OP_PRODUCT_TO_REGISTER, 2'h0, 5'h00, 32'h7fffffff,
            1);
        pair(mii_pkg::OP_UNSIGNED_QUOTIENT, 2'h0,
            mii_pkg::OP_UNSIGNED_QUOTIENT, 2'h0, 5'h00, uv[0],
            1 + `MII_DIV_LAT_8);
    endtask
    task automatic t_acc();
        mii_pkg::mii_op_t sh[3] = '{mii_pkg::OP_ACCUMULATOR_SHIFT,
            mii_pkg::OP_ACCUMULATOR_EXTRACT,
            mii_pkg::OP_ACCUMULATOR_SHIFT_INSERT};
        for (int i = 0; i < 3; i++) begin
            pair(mii_pkg::OP_ACCUMULATE, 2'h3, sh[i], 2'h3, 5'h00, 32'h0,
                1 + `MII_ACC_SHIFT_WAIT);
        end
        pair(mii_pkg::OP_ACCUMULATE, 2'h3, sh[0], 2'h0, 5'h00, 32'h0,
            1);
        drain();
        u_src.offer('{mii_pkg::OP_ACCUMULATE, 2'h2, 5'h00, 5'h00, 5'h00,
            32'h0});
        u_src.offer('{mii_pkg::OP_ALU, 2'h0, 5'h00, 5'h00, 5'h00, 32'h0});
        u_src.offer('{sh[0], 2'h2, 5'h00, 5'h00, 5'h00, 32'h0});
        u_src.idle();
        wait_go(3);
        check(gq[2] - gq[1], `MII_ACC_SHIFT_WAIT);
    endtask
    task automatic t_ctl();
        pair(mii_pkg::OP_ADD_SETTING_CARRY, 2'h0, mii_pkg::OP_ADD_WITH_CARRY,
            2'h0, 5'h00, 32'h1, 1);
        check(out.ctl.carry, 1'b1);
        pair(mii_pkg::OP_VECTOR_COMPARE, 2'h0, mii_pkg::OP_CONDITIONAL_SELECT,
            2'h0, 5'h00, 32'h5, 1);
        check(out.ctl.cond, 4'h5);
        pair(mii_pkg::OP_ACCUMULATE_SAT, 2'h1,
            mii_pkg::OP_CONTROL_REGISTER_READ, 2'h0, 5'h00, 32'h0,
            1 + `MII_OUFLAG_DEPTH);
        pair(mii_pkg::OP_CONTROL_REGISTER_WRITE, 2'h0,
            mii_pkg::OP_VARIABLE_INSERT, 2'h0, 5'h00, 32'h0a002020,
            1);
        check(out.ctl.carry, 1'b1);
        check(out.ctl.cond, 4'ha);
        for (int i = 0; i < 2; i++) begin
            pair(mii_pkg::OP_CONTROL_REGISTER_WRITE, 2'h0,
                mii_pkg::OP_POSITION_TEST_BRANCH, 2'h0, 5'h00,
                i ? 32'h1f : 32'h20, 1);
            check(bq[1], i ? 1'b0 : 1'b1);
            check(out.ctl.pos, i ? 6'h1f : 6'h20);
        end
    endtask
    task automatic t_busy();
        drain();
        wr_port_busy = 1'b1;
        u_src.offer('{mii_pkg::OP_PRODUCT_TO_REGISTER, 2'h0, 5'h00, 5'h00,
            5'h00, 32'h0});
        u_src.idle();
        repeat (6) @(posedge ref_clk);
        #1;
        check(gq.size(), 0);
        wr_port_busy = 1'b0;
        wait_go(1);
    endtask
    task automatic t_reset();
        drain();
        rstn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check(out.ctl, 11'h000);
        check(out.ready, 1'b1);
        rstn = 1'b1;
        t_mac();
    endtask
    initial begin
        rstn = 1'b0;
        wr_port_busy = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        t_mac();
        t_gpr();
        t_div();
        t_acc();
        t_ctl();
        t_busy();
        t_reset();
        end_sim();
    end
endmodule // testbench

// [mii_pkg.sv]
// types shared by the multiply/divide issue interlock
package mii_pkg;
    typedef enum logic [4:0] {
        OP_NONE,
        OP_ALU,
        OP_ALU_DSP,
        OP_PRODUCT_TO_REGISTER,
        OP_PRODUCT_TO_PAIR,
        OP_ACCUMULATE,
        OP_ACCUMULATE_SAT,
        OP_READ_HALF,
        OP_WRITE_HALF,
        OP_ACCUMULATOR_SHIFT,
        OP_ACCUMULATOR_EXTRACT,
        OP_ACCUMULATOR_SHIFT_INSERT,
        OP_SIGNED_QUOTIENT,
        OP_UNSIGNED_QUOTIENT,
        OP_INDEXED_LOAD,
        OP_POSITION_TEST_BRANCH,
        OP_CONTROL_REGISTER_READ,
        OP_CONTROL_REGISTER_WRITE,
        OP_ADD_SETTING_CARRY,
        OP_ADD_WITH_CARRY,
        OP_VECTOR_COMPARE,
        OP_CONDITIONAL_SELECT,
        OP_VARIABLE_INSERT
    } mii_op_t;

    typedef struct packed {
        mii_op_t op;
        logic [1:0] acc;
        logic [4:0] dest;
        logic [4:0] src_a;
        logic [4:0] src_b;
        logic [31:0] operand;
    } mii_instr_t;

    typedef struct packed {
        logic [5:0] pos;
        logic carry;
        logic [3:0] cond;
    } mii_ctl_t;

    typedef struct packed {
        logic ready;
        logic go;
        mii_op_t op;
        logic branch_taken;
        mii_ctl_t ctl;
    } mii_out_t;

    typedef struct packed {
        logic head_v;
        mii_instr_t head;
        logic port_busy;
        logic [31:0][2:0] gpr_cnt;
        logic [3:0][1:0] mac_cnt;
        logic [3:0][1:0] rd_cnt;
        logic [3:0][1:0] sh_cnt;
        logic [5:0] div_cnt;
        logic [2:0] ouflag_cnt;
        mii_ctl_t ctl_ex;
        mii_ctl_t ctl_ms;
        mii_out_t out;
    } mii_state_t;
endpackage
